// File: inc/aept_map.svh
// Purpose: offsets, bit positions and reset values of the pm event block
// Assumes: byte wide i/o port, offsets relative to each block base
// Notes: definitions only
`ifndef AEPT_MAP_SVH
`define AEPT_MAP_SVH
// pm1 block offsets
`define AEPT_PM1_STS_LO 4'h0
`define AEPT_PM1_STS_HI 4'h1
`define AEPT_PM1_EN_LO 4'h2
`define AEPT_PM1_EN_HI 4'h3
`define AEPT_PM1_CTL 4'h4
`define AEPT_PM1_TMR0 4'h8
`define AEPT_PM1_TMR1 4'h9
`define AEPT_PM1_TMR2 4'ha
// first gpe block offsets
`define AEPT_GPE_STS 4'h0
`define AEPT_GPE_EN 4'h2
`define AEPT_GPE_CTL 4'h4
// block sizes in bytes
`define AEPT_PM1_SIZE 16'h0010
`define AEPT_GPE_SIZE 16'h0008
// pm1 status and enable bit positions
`define AEPT_B_TMR 0
`define AEPT_B_BM 4
`define AEPT_B_GBL 5
// pm1 control bit positions
`define AEPT_B_ACPI_EN 0
`define AEPT_B_BM_EN 1
`define AEPT_B_OS_RLS 2
// gpe bit positions
`define AEPT_B_FW_FLAG 0
`define AEPT_B_FW_EN 0
`define AEPT_B_TIMER_RUN_ENABLE 0
`define AEPT_B_FW_RLS 1
`define AEPT_B_BM_REQ 2
// reset values
`define AEPT_RST_BYTE 8'h00
`define AEPT_RST_TIMER_RUN_ENABLE 1'b1
`define AEPT_RST_COUNT 24'h000000
// most significant bit of the pm timer count
`define AEPT_TMR_MSB 23
`endif

// File: inc/aept_pkg.sv
// Purpose: types shared by the pm event block
// Assumes: configuration values come from the same clock domain
// Notes: constants live in aept_map.svh
package aept_pkg;
  // decoded block bases from the configuration space
  typedef struct packed {
    logic [15:0] pm1_base;
    logic [15:0] gpe0_base;
    logic [15:0] gpe1_base;
  } aept_bases_t;
  // interrupt routing choices from the configuration space
  typedef struct packed {
    logic legacy_route_enable;
    logic smi_serial_sel;
    logic serirq_mode;
    logic [3:0] sci_irq_sel;
  } aept_route_t;
endpackage

// File: design/aept_core.sv
// Purpose: pm event status/enable logic, release handshakes and pm timer
// Assumes: i/o strobes, address, data and timer clock arrive from pins
// Notes: interrupt pins are registered; reads show live timer count
`timescale 1ns/1ps
`include "aept_map.svh"

// Behaviour
// [R01] legacy routing sends events to smi
// [R02] acpi routing sends events to sci
// [R03] smi on dedicated pin or serial irq
// [R04] sci on pin, selected irq, serial irq
// [R05] firmware release and global enable raise sci
// [R06] write one firmware release sets global flag
// [R07] write one global flag clears both bits
// [R08] os release and firmware enable raise smi
// [R09] os release handshake with firmware event flag
// [R10] busmaster request and enable raise sci
// [R11] busmaster flag at bit four handshake
// [R12] free running 24-bit up counter
// [R13] bit 23 change sets timer flag
// [R14] timer flag with enable raises sci
// [R15] three byte registers read timer count
// [R16] run enable low halts the timer
// [R17] status sets always; enable gates interrupt
// [R18] status and enable pairs, same positions
// [R19] status bits cleared by writing one
// [R20] reserved bits read zero, ignore writes
// [R21] block bases decoded from configuration registers
// [R22] status byte resets zero, bits 0,5
// [R23] enable byte offset two, bits 0,5
module aept_core
  import aept_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // i/o port pins
  input wire logic io_rd_n_in,
  input wire logic io_wr_n_in,
  input wire logic io_aen_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [7:0] io_data_in,
  output logic [7:0] io_data_out,
  output logic io_data_oe_out,
  // configuration space values
  input wire aept_bases_t cfg_bases_in,
  input wire aept_route_t cfg_route_in,
  // timer clock pin
  input wire logic pm_timer_clk_in,
  // interrupt outputs
  output logic smi_n_out,
  output logic sci_n_out,
  output logic [15:0] irq_out,
  output logic serial_irq_smi_req_out,
  output logic serial_irq_sci_req_out
);

  // registers of the block
  logic timer_toggle_flag_r;
  logic busmaster_event_flag_r;
  logic global_event_flag_r;
  logic timer_event_enable_r;
  logic global_event_enable_r;
  logic acpi_route_enable_r;
  logic busmaster_event_enable_r;
  logic os_release_r;
  logic firmware_event_flag_r;
  logic firmware_event_enable_r;
  logic timer_run_enable_r;
  logic firmware_release_r;
  logic busmaster_request_r;
  logic [23:0] count_r;
  logic [23:0] count_nxt;
  // pin synchronisers
  logic rd_n_s1_r, rd_n_s2_r, wr_n_s1_r, wr_n_s2_r, wr_n_s3_r;
  logic aen_s1_r, aen_s2_r, tclk_s1_r, tclk_s2_r, tclk_s3_r;
  logic [15:0] addr_s1_r, addr_s2_r;
  logic [7:0] data_s1_r, data_s2_r;
  // decode
  logic wr_p, rd_act, tick, toggle;
  logic pm1_hit, gpe0_hit, gpe1_hit;
  logic [3:0] pm1_off, gpe_off;
  logic [7:0] rdata_nxt;
  logic sci_ev, smi_ev, sci_act, smi_act;

  // true when addr falls inside the block at base
  function automatic logic blk_hit(input logic [15:0] a, input logic [15:0] base,
                                   input logic [15:0] size);
    logic [15:0] d;
    d = 16'(a - base);
    return d < size;
  endfunction

  // write strobe landing on one bit of one register
  function automatic logic wr_bit(input logic hit, input logic [3:0] off,
                                  input logic [3:0] want, input logic dbit);
    return hit && (off == want) && dbit;
  endfunction

  // two-flop synchronisers for every pin input, with a third flop on the write strobe and the timer clock
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_n_s1_r <= 1'b1;
      rd_n_s2_r <= 1'b1;
      wr_n_s1_r <= 1'b1;
      wr_n_s2_r <= 1'b1;
      wr_n_s3_r <= 1'b1;
      aen_s1_r <= 1'b1;
      aen_s2_r <= 1'b1;
      addr_s1_r <= 16'h0000;
      addr_s2_r <= 16'h0000;
      data_s1_r <= 8'h00;
      data_s2_r <= 8'h00;
      tclk_s1_r <= 1'b0;
      tclk_s2_r <= 1'b0;
      tclk_s3_r <= 1'b0;
    end else begin
      rd_n_s1_r <= io_rd_n_in;
      rd_n_s2_r <= rd_n_s1_r;
      wr_n_s1_r <= io_wr_n_in;
      wr_n_s2_r <= wr_n_s1_r;
      wr_n_s3_r <= wr_n_s2_r;
      aen_s1_r <= io_aen_in;
      aen_s2_r <= aen_s1_r;
      addr_s1_r <= io_addr_in;
      addr_s2_r <= addr_s1_r;
      data_s1_r <= io_data_in;
      data_s2_r <= data_s1_r;
      tclk_s1_r <= pm_timer_clk_in;
      tclk_s2_r <= tclk_s1_r;
      tclk_s3_r <= tclk_s2_r;
    end
  end

  // block decode; writes commit on the trailing edge of the strobe
  assign pm1_hit = !aen_s2_r && blk_hit(addr_s2_r, cfg_bases_in.pm1_base,
                                        `AEPT_PM1_SIZE); // R21
  assign gpe0_hit = !aen_s2_r && blk_hit(addr_s2_r, cfg_bases_in.gpe0_base,
                                         `AEPT_GPE_SIZE); // R21
  assign gpe1_hit = !aen_s2_r && blk_hit(addr_s2_r, cfg_bases_in.gpe1_base,
                                         `AEPT_GPE_SIZE); // R21
  assign pm1_off = 4'(addr_s2_r - cfg_bases_in.pm1_base);
  assign gpe_off = 4'(addr_s2_r - cfg_bases_in.gpe0_base);
  assign wr_p = wr_n_s2_r && !wr_n_s3_r;
  assign rd_act = !rd_n_s2_r;

  // timer advance on each rising edge of the timer clock while run enable is set
  assign tick = tclk_s2_r && !tclk_s3_r && timer_run_enable_r; // R16
  assign count_nxt = 24'(count_r + 24'h000001); // R12
  assign toggle = tick && (count_nxt[`AEPT_TMR_MSB] != count_r[`AEPT_TMR_MSB]); // R13

  // pm timer counter
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count_r <= `AEPT_RST_COUNT;
    end else if (tick) begin
      count_r <= count_nxt; // R12
    end
  end

  // timer toggle flag; a toggle beats a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      timer_toggle_flag_r <= 1'b0; // R22
    end else if (toggle) begin
      timer_toggle_flag_r <= 1'b1; // R13 R17
    end else if (wr_p && wr_bit(pm1_hit, pm1_off, `AEPT_PM1_STS_LO,
                                data_s2_r[`AEPT_B_TMR])) begin
      timer_toggle_flag_r <= 1'b0; // R19
    end
  end

  // firmware to os handshake
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      firmware_release_r <= 1'b0;
      global_event_flag_r <= 1'b0; // R22
    end else if (wr_p && wr_bit(gpe0_hit, gpe_off, `AEPT_GPE_CTL,
                                data_s2_r[`AEPT_B_FW_RLS])) begin
      firmware_release_r <= 1'b1; // R06
      global_event_flag_r <= 1'b1; // R06
    end else if (wr_p && wr_bit(pm1_hit, pm1_off, `AEPT_PM1_STS_LO,
                                data_s2_r[`AEPT_B_GBL])) begin
      firmware_release_r <= 1'b0; // R07
      global_event_flag_r <= 1'b0; // R07
    end
  end

  // os to firmware handshake
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      os_release_r <= 1'b0;
      firmware_event_flag_r <= 1'b0;
    end else if (wr_p && wr_bit(pm1_hit, pm1_off, `AEPT_PM1_CTL,
                                data_s2_r[`AEPT_B_OS_RLS])) begin
      os_release_r <= 1'b1; // R09
      firmware_event_flag_r <= 1'b1; // R09
    end else if (wr_p && wr_bit(gpe0_hit, gpe_off, `AEPT_GPE_STS,
                                data_s2_r[`AEPT_B_FW_FLAG])) begin
      os_release_r <= 1'b0; // R09
      firmware_event_flag_r <= 1'b0; // R09
    end
  end

  // bus master handshake
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      busmaster_request_r <= 1'b0;
      busmaster_event_flag_r <= 1'b0;
    end else if (wr_p && wr_bit(gpe0_hit, gpe_off, `AEPT_GPE_CTL,
                                data_s2_r[`AEPT_B_BM_REQ])) begin
      busmaster_request_r <= 1'b1; // R11
      busmaster_event_flag_r <= 1'b1; // R11
    end else if (wr_p && wr_bit(pm1_hit, pm1_off, `AEPT_PM1_STS_LO,
                                data_s2_r[`AEPT_B_BM])) begin
      busmaster_request_r <= 1'b0; // R11
      busmaster_event_flag_r <= 1'b0; // R11
    end
  end

  // plain enable and control bits; other bits are not stored
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      timer_event_enable_r <= 1'b0; // R23
      global_event_enable_r <= 1'b0; // R23
      acpi_route_enable_r <= 1'b0;
      busmaster_event_enable_r <= 1'b0;
      firmware_event_enable_r <= 1'b0;
      timer_run_enable_r <= `AEPT_RST_TIMER_RUN_ENABLE;
    end else if (wr_p) begin
      if (pm1_hit && pm1_off == `AEPT_PM1_EN_LO) begin
        timer_event_enable_r <= data_s2_r[`AEPT_B_TMR]; // R18 R23
        global_event_enable_r <= data_s2_r[`AEPT_B_GBL]; // R18 R23
      end
      if (pm1_hit && pm1_off == `AEPT_PM1_CTL) begin
        acpi_route_enable_r <= data_s2_r[`AEPT_B_ACPI_EN];
        busmaster_event_enable_r <= data_s2_r[`AEPT_B_BM_EN];
      end
      if (gpe0_hit && gpe_off == `AEPT_GPE_EN) begin
        firmware_event_enable_r <= data_s2_r[`AEPT_B_FW_EN]; // R18
      end
      if (gpe0_hit && gpe_off == `AEPT_GPE_CTL) begin
        timer_run_enable_r <= data_s2_r[`AEPT_B_TIMER_RUN_ENABLE]; // R16
      end
    end
  end

  // read data mux; reserved and unmapped bits read zero
  always_comb begin
    rdata_nxt = `AEPT_RST_BYTE;
    if (pm1_hit) begin
      case (pm1_off)
        `AEPT_PM1_STS_LO: begin
          rdata_nxt[`AEPT_B_TMR] = timer_toggle_flag_r; // R22
          rdata_nxt[`AEPT_B_BM] = busmaster_event_flag_r; // R11
          rdata_nxt[`AEPT_B_GBL] = global_event_flag_r; // R22
        end
        `AEPT_PM1_EN_LO: begin
          rdata_nxt[`AEPT_B_TMR] = timer_event_enable_r; // R23
          rdata_nxt[`AEPT_B_GBL] = global_event_enable_r; // R23
        end
        `AEPT_PM1_CTL: begin
          rdata_nxt[`AEPT_B_ACPI_EN] = acpi_route_enable_r;
          rdata_nxt[`AEPT_B_BM_EN] = busmaster_event_enable_r;
          rdata_nxt[`AEPT_B_OS_RLS] = os_release_r;
        end
        `AEPT_PM1_TMR0: rdata_nxt = count_r[7:0]; // R15
        `AEPT_PM1_TMR1: rdata_nxt = count_r[15:8]; // R15
        `AEPT_PM1_TMR2: rdata_nxt = count_r[23:16]; // R15
        default: rdata_nxt = `AEPT_RST_BYTE; // R20
      endcase
    end else if (gpe0_hit) begin
      case (gpe_off)
        `AEPT_GPE_STS: rdata_nxt[`AEPT_B_FW_FLAG] = firmware_event_flag_r;
        `AEPT_GPE_EN: rdata_nxt[`AEPT_B_FW_EN] = firmware_event_enable_r;
        `AEPT_GPE_CTL: begin
          rdata_nxt[`AEPT_B_TIMER_RUN_ENABLE] = timer_run_enable_r;
          rdata_nxt[`AEPT_B_FW_RLS] = firmware_release_r;
          rdata_nxt[`AEPT_B_BM_REQ] = busmaster_request_r;
        end
        default: rdata_nxt = `AEPT_RST_BYTE; // R20
      endcase
    end
  end

  // read data registered every cycle; output enable follows the synced read strobe
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      io_data_out <= 8'h00;
      io_data_oe_out <= 1'b0;
    end else begin
      io_data_out <= rdata_nxt;
      io_data_oe_out <= rd_act && (pm1_hit || gpe0_hit || gpe1_hit);
    end
  end

  // event gathering and routing
  assign sci_ev = (timer_toggle_flag_r && timer_event_enable_r) // R14 R17
               || (firmware_release_r && global_event_enable_r) // R05
               || (busmaster_request_r && busmaster_event_enable_r); // R10
  assign smi_ev = os_release_r && firmware_event_enable_r; // R08
  assign sci_act = sci_ev && acpi_route_enable_r; // R02
  assign smi_act = smi_ev || (sci_ev && cfg_route_in.legacy_route_enable); // R01

  // interrupt pins, registered
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      smi_n_out <= 1'b1;
      sci_n_out <= 1'b1;
      irq_out <= 16'h0000;
      serial_irq_smi_req_out <= 1'b0;
      serial_irq_sci_req_out <= 1'b0;
    end else begin
      smi_n_out <= !(smi_act && !cfg_route_in.smi_serial_sel); // R03
      serial_irq_smi_req_out <= smi_act && cfg_route_in.smi_serial_sel; // R03
      sci_n_out <= !sci_act; // R04
      irq_out <= 16'h0000;
      if (cfg_route_in.sci_irq_sel != 4'h0) begin
        irq_out[cfg_route_in.sci_irq_sel] <= sci_act; // R04
      end
      serial_irq_sci_req_out <= sci_act && cfg_route_in.serirq_mode; // R04
    end
  end

  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_fw_rls_set: assert property ( // R06
    wr_p && wr_bit(gpe0_hit, gpe_off, `AEPT_GPE_CTL, data_s2_r[`AEPT_B_FW_RLS])
    |=> firmware_release_r && global_event_flag_r)
    else $error("firmware release write did not set both bits");
  a_gbl_clear: assert property ( // R07
    wr_p && wr_bit(pm1_hit, pm1_off, `AEPT_PM1_STS_LO, data_s2_r[`AEPT_B_GBL])
    && !(gpe0_hit && gpe_off == `AEPT_GPE_CTL)
    |=> !global_event_flag_r && !firmware_release_r)
    else $error("global flag clear did not clear both bits");
  a_os_handshake: assert property ( // R09
    wr_p && wr_bit(pm1_hit, pm1_off, `AEPT_PM1_CTL, data_s2_r[`AEPT_B_OS_RLS])
    |=> os_release_r && firmware_event_flag_r)
    else $error("os release write did not set both bits");
  a_bm_clear: assert property ( // R11
    wr_p && wr_bit(pm1_hit, pm1_off, `AEPT_PM1_STS_LO, data_s2_r[`AEPT_B_BM])
    && !(gpe0_hit && gpe_off == `AEPT_GPE_CTL)
    |=> !busmaster_request_r && !busmaster_event_flag_r)
    else $error("busmaster flag clear failed");
  a_tmr_toggle: assert property ( // R13
    tick && count_r[`AEPT_TMR_MSB] != count_nxt[`AEPT_TMR_MSB]
    |=> timer_toggle_flag_r ##1 timer_toggle_flag_r || $past(wr_p))
    else $error("msb change did not set timer flag");
  a_tmr_halt: assert property ( // R16
    !timer_run_enable_r |=> $stable(count_r))
    else $error("timer moved while halted");
  a_sci_pin: assert property ( // R14
    timer_toggle_flag_r && timer_event_enable_r && acpi_route_enable_r
    |=> !sci_n_out)
    else $error("enabled timer flag did not assert sci");
  a_sci_route: assert property ( // R02
    sci_ev && acpi_route_enable_r |=> !sci_n_out)
    else $error("acpi routed event did not assert sci");
  a_smi_pin: assert property ( // R08
    os_release_r && firmware_event_enable_r && !cfg_route_in.smi_serial_sel
    |=> !smi_n_out)
    else $error("os release did not assert smi");
  a_rsvd_zero: assert property ( // R20
    $past(pm1_hit && pm1_off == `AEPT_PM1_STS_HI) |-> io_data_out == 8'h00)
    else $error("reserved register read nonzero");

endmodule // aept_core

// File: sim/aept_host_model.sv
// Purpose: host side of the pm event block, data bus and interrupt inputs
// Assumes: one party drives the data bus at a time
// Notes: a released bus shows the inverse of its last driven value
`timescale 1ns/1ps
module aept_host_model (
  // clock
  input wire logic clk_in,
  // data bus parties
  input wire logic host_drive_in,
  input wire logic [7:0] host_data_in,
  input wire logic [7:0] dev_data_in,
  input wire logic dev_oe_in,
  output logic [7:0] bus_out,
  // interrupt inputs of the chipset
  input wire logic sci_n_in,
  input wire logic [15:0] irq_in,
  input wire logic serial_sci_in,
  output logic sci_seen_out
);
  logic [7:0] last_r = 8'h00;
  // wire level from both enables; floating bus never repeats old data
  assign bus_out = dev_oe_in ? dev_data_in : (host_drive_in ? host_data_in : ~last_r);
  // remember the last driven value
  always_ff @(posedge clk_in) begin
    if (host_drive_in || dev_oe_in) begin
      last_r <= bus_out;
    end
  end
  // any of the three sci paths reaches the host
  assign sci_seen_out = !sci_n_in || (|irq_in) || serial_sci_in;
endmodule // aept_host_model

// File: sim/test_acpi_event_and_pm_timer.sv
// Purpose: self-checking bench of the pm event block
// Assumes: write strobes held 4 cycles after 3 cycles of setup; read strobes held 5 cycles after 2 cycles of setup
// Notes: timer flag toggle needs 2^23 ticks, so it is left to assertions
`timescale 1ns/1ps
module test_acpi_event_and_pm_timer;
  import aept_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, rd_n = 1'b1, wr_n = 1'b1, aen = 1'b0;
  logic tclk = 1'b0, drv = 1'b0, oe, smi_n, sci_n, ssmi, ssci, host_sci, ro;
  logic [15:0] addr = 16'h0000, irq, p, g, q;
  logic [7:0] hdata = 8'h00, bus, dout, rv, t0, t1, d;
  aept_bases_t bases = '0;
  aept_route_t route = '0;
  int n_errors = 0, compares = 0, cycles = 0;
  // clocks: system 40 mhz, timer oscillator unrelated in phase
  always #12.5 clk_in = ~clk_in;
  always #139.682 tclk = ~tclk;
  aept_core aept_core_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .io_rd_n_in(rd_n),
    .io_wr_n_in(wr_n), .io_aen_in(aen), .io_addr_in(addr), .io_data_in(bus),
    .io_data_out(dout), .io_data_oe_out(oe), .cfg_bases_in(bases), .cfg_route_in(route),
    .pm_timer_clk_in(tclk), .smi_n_out(smi_n), .sci_n_out(sci_n), .irq_out(irq),
    .serial_irq_smi_req_out(ssmi), .serial_irq_sci_req_out(ssci));
  aept_host_model aept_host_model_inst (.clk_in(clk_in), .host_drive_in(drv),
    .host_data_in(hdata), .dev_data_in(dout), .dev_oe_in(oe), .bus_out(bus),
    .sci_n_in(sci_n), .irq_in(irq), .serial_sci_in(ssci), .sci_seen_out(host_sci));
  // compare and count
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // i/o write: setup, 4 cycles low, then wait until pins settle
  task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    hdata <= v;
    drv <= 1'b1;
    repeat (3) @(posedge clk_in);
    wr_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    wr_n <= 1'b1;
    repeat (8) @(posedge clk_in);
    drv <= 1'b0;
  endtask
  // i/o read: data and enable sampled once settled
  task automatic io_rd(input logic [15:0] a, output logic [7:0] v, output logic o);
    @(posedge clk_in);
    addr <= a;
    repeat (2) @(posedge clk_in);
    rd_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    v = dout;
    o = oe;
    @(posedge clk_in);
    rd_n <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    logic o;
    io_rd(a, v, o);
    check({what, " oe"}, o, 1'b1);
    check(what, v, exp);
  endtask
  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    void'($urandom(54));
    p = {2'b01, 14'($urandom) & 14'h3ff0};
    g = {2'b10, 14'($urandom) & 14'h3ff8};
    q = {2'b11, 14'($urandom) & 14'h3ff8};
    bases <= '{pm1_base: p, gpe0_base: g, gpe1_base: q};
    route <= '{legacy_route_enable: 1'b0, smi_serial_sel: 1'($urandom),
      serirq_mode: 1'($urandom), sci_irq_sel: 4'($urandom_range(15, 1))};
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd_chk(p + 16'h0000, 8'h00, "pm1 status lo");
    rd_chk(p + 16'h0002, 8'h00, "pm1 enable lo");
    rd_chk(p + 16'h0004, 8'h00, "pm1 control");
    rd_chk(g + 16'h0004, 8'h01, "gpe0 control");
    check("idle pins", {smi_n, sci_n, ssmi, ssci, irq}, 20'hc0000);
    // firmware release towards the acpi side
    io_wr(p + 16'h0002, 8'h20);
    io_wr(p + 16'h0004, 8'h01);
    check("sci no event", sci_n, 1'b1);
    io_wr(g + 16'h0004, 8'h03);
    rd_chk(p + 16'h0000, 8'h20, "global flag set");
    check("sci pin", sci_n, 1'b0);
    check("sci irq line", irq, 16'h0001 << route.sci_irq_sel);
    check("sci serial", ssci, route.serirq_mode);
    check("host sees sci", host_sci, 1'b1);
    io_wr(g + 16'h0004, 8'h01);
    rd_chk(g + 16'h0004, 8'h03, "release kept");
    io_wr(p + 16'h0000, 8'h00);
    rd_chk(p + 16'h0000, 8'h20, "flag kept");
    io_wr(p + 16'h0000, 8'h20);
    rd_chk(p + 16'h0000, 8'h00, "flag cleared");
    rd_chk(g + 16'h0004, 8'h01, "release cleared");
    check("sci released", {sci_n, irq}, 17'h10000);
    // os release towards the firmware side, both smi paths
    io_wr(g + 16'h0002, 8'h01);
    io_wr(p + 16'h0004, 8'h05);
    rd_chk(g + 16'h0000, 8'h01, "firmware flag");
    repeat (2) begin
      check("smi path", {smi_n, ssmi}, route.smi_serial_sel ? 2'b11 : 2'b00);
      @(posedge clk_in);
      route.smi_serial_sel <= ~route.smi_serial_sel;
      repeat (3) @(posedge clk_in);
    end
    io_wr(g + 16'h0000, 8'h01);
    rd_chk(p + 16'h0004, 8'h01, "os release cleared");
    check("smi released", {smi_n, ssmi}, 2'b10);
    // bus master request
    io_wr(p + 16'h0004, 8'h03);
    io_wr(g + 16'h0004, 8'h05);
    rd_chk(p + 16'h0000, 8'h10, "busmaster flag");
    check("sci busmaster", sci_n, 1'b0);
    io_wr(p + 16'h0000, 8'h10);
    rd_chk(g + 16'h0004, 8'h01, "request cleared");
    check("sci idle", sci_n, 1'b1);
    // legacy routing of the global event
    route.legacy_route_enable <= 1'b1;
    io_wr(p + 16'h0004, 8'h00);
    io_wr(g + 16'h0004, 8'h03);
    check("no acpi sci", sci_n, 1'b1);
    check("legacy smi", {smi_n, ssmi}, route.smi_serial_sel ? 2'b11 : 2'b00);
    io_wr(p + 16'h0000, 8'h20);
    route.legacy_route_enable <= 1'b0;
    // reserved bits and random enable patterns
    repeat (6) begin
      d = 8'($urandom);
      io_wr(p + 16'h0002, d);
      rd_chk(p + 16'h0002, d & 8'h21, "enable lo");
    end
    io_wr(p + 16'h0001, 8'hff);
    rd_chk(p + 16'h0001, 8'h00, "status hi");
    io_wr(p + 16'h0000, 8'hff);
    rd_chk(p + 16'h0000, 8'h00, "status no set");
    // refused accesses and decode of the other blocks
    io_wr(p + 16'h0002, 8'h00);
    aen <= 1'b1;
    io_wr(p + 16'h0002, 8'h21);
    aen <= 1'b0;
    rd_chk(p + 16'h0002, 8'h00, "dma cycle ignored");
    io_rd(16'h0300, rv, ro);
    check("unmapped oe", ro, 1'b0);
    rd_chk(q, 8'h00, "gpe1 block");
    // timer runs up, then halts
    io_rd(p + 16'h0008, t0, ro);
    repeat (100) @(posedge clk_in);
    io_rd(p + 16'h0008, t1, ro);
    d = t1 - t0;
    check("timer advance", (d >= 8'd8) && (d <= 8'd20), 1'b1);
    io_wr(g + 16'h0004, 8'h00);
    for (int i = 0; i < 3; i++) begin
      io_rd(p + 16'h0008 + 16'(i), t0, ro);
      repeat (60) @(posedge clk_in);
      io_rd(p + 16'h0008 + 16'(i), t1, ro);
      check("timer halted", t1, t0);
    end
    check("timer high byte", t1, 8'h00);
    wrap_up();
  end
endmodule // test_acpi_event_and_pm_timer
